/* verilog/rmc_defines.vh */
// constants for the reader mode and port command handler
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH
`define RMC_CLK_HZ        25000000
`define RMC_BAUD_1200     1200
`define RMC_BAUD_2400     2400
`define RMC_BAUD_4800     4800
`define RMC_BAUD_9600     9600
`define RMC_BAUD_19200    19200
`define RMC_BAUD_38400    38400
`define RMC_RATE_DEFAULT  3'h5
`define RMC_RATE_DOWNLOAD 3'h7
`define RMC_CH_SOM        8'h23
`define RMC_CH_EOM        8'h0d
`define RMC_CH_XON        8'h11
`define RMC_CH_XOFF       8'h13
`define RMC_MAX_DIGITS    4'h8
`define RMC_MODE_DATA     2'h0
`define RMC_MODE_CMD      2'h1
`define RMC_MODE_DL       2'h2
`define RMC_RSP_DONE      1'b0
`define RMC_RSP_ERROR     1'b1
`define RMC_FIFO_DEPTH    16
`define RMC_FIFO_WIDTH    8
`endif

/* verilog/rmc_fifo.v */
// synchronous first-in first-out buffer for transmit characters
`timescale 1ns/1ns
module rmc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_reg;
	reg [AW-1:0]    rd_reg;
	reg [AW:0]      cnt_reg;
	wire            push;
	wire            pop;

	assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
	assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
	assign out_data_o  = mem_reg[rd_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push)
			mem_reg[wr_reg] <= in_data_i;
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_reg  <= {AW{1'b0}};
			rd_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

/* verilog/rmc_handler.v */
// reader mode and serial-port command handler
// Summary of operation
// - three modes: data, command, download
// - data mode after reset
// - tag and report messages only in data mode
// - extended data mode accepts small command set
// - 440 pulses uniqueness timer reset once
// - 811N powers RF port, fires check-tag
// - 815N sets check-tag address per pin
// - command mode answers every frame of up to 8 hex digits
// - new baud rate after Done finishes
// - download forces 38400 8N1 with XON/XOFF
// - download: RF off, no tags, no echo
// - hex digits accepted in either case
// - 00 enters data mode, saves changes
// - 01 enters command mode, RF off
// - 100N selects baud rate
// - 101N selects one or two stop bits
`timescale 1ns/1ns
`include "rmc_defines.vh"
module rmc_handler #(
	parameter CLK_HZ = `RMC_CLK_HZ
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       rx_valid_i,
	input  wire [7:0] rx_data_i,
	output wire       tx_valid_o,
	input  wire       tx_ready_i,
	output wire [7:0] tx_data_o,
	input  wire       tx_idle_i,
	input  wire       msg_valid_i,
	output wire       msg_ready_o,
	input  wire [7:0] msg_data_i,
	input  wire       download_req_i,
	input  wire       extended_enable_i,
	output reg  [1:0] mode_o,
	output reg  [2:0] baud_sel_o,
	output reg [15:0] baud_div_o,
	output reg        two_stop_o,
	output reg        xon_xoff_o,
	output reg        rf_enable_o,
	output reg  [3:0] rf_port_o,
	output reg        tag_enable_o,
	output reg        uniq_reset_o,
	output reg        ctag_fire_o,
	output reg        ctag_pin_o,
	output reg  [1:0] ctag_addr_o,
	output reg        nv_save_o,
	output reg        nv_dirty_o
);
	localparam S_IDLE = 2'h0;
	localparam S_BODY = 2'h1;
	localparam S_EXEC = 2'h2;
	// reset divisor, cut to the 16-bit port on use
	localparam [31:0] DIV_RESET = CLK_HZ / `RMC_BAUD_9600;

	reg  [1:0]  pstate_reg;
	reg  [31:0] digits_reg;
	reg  [3:0]  ndig_reg;
	reg  [2:0]  pend_rate_reg;
	reg         pend_rate_vld_reg;
	reg  [2:0]  rsp_idx_reg;
	reg         rsp_kind_reg;
	reg         rsp_busy_reg;
	reg         ext_reg;
	reg  [2:0]  user_rate_reg;
	reg         user_two_stop_reg;
	reg  [7:0]  q_data;
	reg         q_valid;
	wire        q_ready;
	wire        rsp_push;
	wire        msg_push;
	wire        is_hex;
	wire [3:0]  hex_val;
	reg         echo_pend_reg;
	reg  [7:0]  echo_reg;

	function [3:0] rmc_hex;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				rmc_hex = c[3:0];
			else
				rmc_hex = c[3:0] + 4'h9;
		end
	endfunction

	function rmc_is_hex;
		input [7:0] c;
		begin
			rmc_is_hex = (c >= 8'h30 && c <= 8'h39) ||
				(c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
		end
	endfunction

	function [15:0] rmc_div;
		input [2:0] sel;
		reg   [31:0] baud;
		reg   [31:0] ratio;
		begin
			case (sel)
				3'h2:    baud = `RMC_BAUD_1200;
				3'h3:    baud = `RMC_BAUD_2400;
				3'h4:    baud = `RMC_BAUD_4800;
				3'h6:    baud = `RMC_BAUD_19200;
				3'h7:    baud = `RMC_BAUD_38400;
				default: baud = `RMC_BAUD_9600;
			endcase
			ratio   = CLK_HZ / baud;
			rmc_div = ratio[15:0];
		end
	endfunction

	assign is_hex  = rmc_is_hex(rx_data_i);
	assign hex_val = rmc_hex(rx_data_i);

	// response text: start character, "Done" or "Error", then end character
	function [7:0] rmc_rsp_char;
		input       kind;
		input [2:0] idx;
		begin
			if (kind == `RMC_RSP_DONE) begin
				case (idx)
					3'h0:    rmc_rsp_char = `RMC_CH_SOM;
					3'h1:    rmc_rsp_char = 8'h44;
					3'h2:    rmc_rsp_char = 8'h6f;
					3'h3:    rmc_rsp_char = 8'h6e;
					3'h4:    rmc_rsp_char = 8'h65;
					default: rmc_rsp_char = `RMC_CH_EOM;
				endcase
			end else begin
				case (idx)
					3'h0:    rmc_rsp_char = `RMC_CH_SOM;
					3'h1:    rmc_rsp_char = 8'h45;
					3'h2:    rmc_rsp_char = 8'h72;
					3'h3:    rmc_rsp_char = 8'h72;
					3'h4:    rmc_rsp_char = 8'h6f;
					3'h5:    rmc_rsp_char = 8'h72;
					default: rmc_rsp_char = `RMC_CH_EOM;
				endcase
			end
		end
	endfunction

	// queue arbitration: response, then echo, then data messages
	assign rsp_push    = rsp_busy_reg & q_ready;
	assign msg_push    = ~rsp_busy_reg & ~echo_pend_reg & q_ready & msg_valid_i &
		(mode_o == `RMC_MODE_DATA);
	assign msg_ready_o = msg_push;

	always @* begin
		q_valid = 1'b0;
		q_data  = 8'h00;
		if (rsp_busy_reg) begin
			q_valid = 1'b1;
			q_data  = rmc_rsp_char(rsp_kind_reg, rsp_idx_reg);
		end else if (echo_pend_reg) begin
			q_valid = 1'b1;
			q_data  = echo_reg;
		end else if (msg_push) begin
			q_valid = 1'b1;
			q_data  = msg_data_i;
		end
	end

	rmc_fifo #(
		.WIDTH (`RMC_FIFO_WIDTH),
		.DEPTH (`RMC_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (q_valid),
		.in_ready_o  (q_ready),
		.in_data_i   (q_data),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_data_o)
	);

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pstate_reg        <= S_IDLE;
			digits_reg        <= 32'h0000_0000;
			ndig_reg          <= 4'h0;
			pend_rate_reg     <= `RMC_RATE_DEFAULT;
			pend_rate_vld_reg <= 1'b0;
			rsp_idx_reg       <= 3'h0;
			rsp_kind_reg      <= `RMC_RSP_DONE;
			rsp_busy_reg      <= 1'b0;
			ext_reg           <= 1'b0;
			user_rate_reg     <= `RMC_RATE_DEFAULT;
			user_two_stop_reg <= 1'b0;
			echo_pend_reg     <= 1'b0;
			echo_reg          <= 8'h00;
			mode_o            <= `RMC_MODE_DATA;
			baud_sel_o        <= `RMC_RATE_DEFAULT;
			baud_div_o        <= DIV_RESET[15:0];
			two_stop_o        <= 1'b0;
			xon_xoff_o        <= 1'b0;
			rf_enable_o       <= 1'b1;
			rf_port_o         <= 4'h0;
			tag_enable_o      <= 1'b1;
			uniq_reset_o      <= 1'b0;
			ctag_fire_o       <= 1'b0;
			ctag_pin_o        <= 1'b0;
			ctag_addr_o       <= 2'h0;
			nv_save_o         <= 1'b0;
			nv_dirty_o        <= 1'b0;
		end else begin
			uniq_reset_o <= 1'b0;
			ctag_fire_o  <= 1'b0;
			nv_save_o    <= 1'b0;
			ext_reg      <= extended_enable_i;
			if (echo_pend_reg && q_ready && !rsp_busy_reg)
				echo_pend_reg <= 1'b0;
			if (rsp_push) begin
				if (q_data == `RMC_CH_EOM) begin
					rsp_busy_reg <= 1'b0;
					rsp_idx_reg  <= 3'h0;
				end else
					rsp_idx_reg <= rsp_idx_reg + 3'h1;
			end
			// rate switches only once Done has fully left the line
			if (pend_rate_vld_reg && !rsp_busy_reg && !tx_valid_o && tx_idle_i &&
				mode_o != `RMC_MODE_DL) begin
				baud_sel_o        <= pend_rate_reg;
				baud_div_o        <= rmc_div(pend_rate_reg);
				pend_rate_vld_reg <= 1'b0;
			end
			if (download_req_i && mode_o == `RMC_MODE_CMD) begin
				mode_o       <= `RMC_MODE_DL;
				baud_sel_o   <= `RMC_RATE_DOWNLOAD;
				baud_div_o   <= rmc_div(`RMC_RATE_DOWNLOAD);
				two_stop_o   <= 1'b0;
				xon_xoff_o   <= 1'b1;
				rf_enable_o  <= 1'b0;
				tag_enable_o <= 1'b0;
				pstate_reg   <= S_IDLE;
				// download fixes the port, so a queued rate is dropped
				pend_rate_vld_reg <= 1'b0;
			end else if (mode_o != `RMC_MODE_DL) begin
				case (pstate_reg)
					S_IDLE: begin
						if (rx_valid_i && rx_data_i == `RMC_CH_SOM) begin
							pstate_reg <= S_BODY;
							ndig_reg   <= 4'h0;
							digits_reg <= 32'h0000_0000;
						end
					end
					S_BODY: begin
						if (rx_valid_i) begin
							if (mode_o == `RMC_MODE_CMD) begin
								echo_pend_reg <= 1'b1;
								echo_reg      <= rx_data_i;
							end
							if (rx_data_i == `RMC_CH_EOM)
								pstate_reg <= S_EXEC;
							else if (rx_data_i == `RMC_CH_SOM) begin
								ndig_reg   <= 4'h0;
								digits_reg <= 32'h0000_0000;
							end else if (is_hex && ndig_reg != `RMC_MAX_DIGITS) begin
								digits_reg <= {digits_reg[27:0], hex_val};
								ndig_reg   <= ndig_reg + 4'h1;
							end else
								pstate_reg <= S_IDLE;
						end
					end
					S_EXEC: begin
						if (!rsp_busy_reg) begin
							pstate_reg <= S_IDLE;
							if (mode_o == `RMC_MODE_CMD) begin
								rsp_busy_reg <= 1'b1;
								rsp_kind_reg <= `RMC_RSP_ERROR;
								if (ndig_reg == 4'h2 && digits_reg[7:0] == 8'h00) begin
									rsp_kind_reg <= `RMC_RSP_DONE;
									mode_o       <= `RMC_MODE_DATA;
									rf_enable_o  <= 1'b1;
									tag_enable_o <= 1'b1;
									nv_save_o    <= nv_dirty_o;
									nv_dirty_o   <= 1'b0;
								end else if (ndig_reg == 4'h2 && digits_reg[7:0] == 8'h01)
									rsp_kind_reg <= `RMC_RSP_DONE;
								else if (ndig_reg == 4'h4 && digits_reg[15:4] == 12'h100 &&
									digits_reg[3:0] >= 4'h2 && digits_reg[3:0] <= 4'h7) begin
									rsp_kind_reg      <= `RMC_RSP_DONE;
									pend_rate_reg     <= digits_reg[2:0];
									pend_rate_vld_reg <= 1'b1;
									user_rate_reg     <= digits_reg[2:0];
									// only a real change marks the settings dirty
									nv_dirty_o        <= nv_dirty_o | (digits_reg[2:0] != user_rate_reg);
								end else if (ndig_reg == 4'h4 && digits_reg[15:4] == 12'h101 &&
									digits_reg[3:1] == 3'h0) begin
									rsp_kind_reg      <= `RMC_RSP_DONE;
									two_stop_o        <= digits_reg[0];
									user_two_stop_reg <= digits_reg[0];
									nv_dirty_o        <= nv_dirty_o | (digits_reg[0] != user_two_stop_reg);
								end
							end else begin
								// 01 always, extended subset only when enabled; anything else dropped silently
								if (ndig_reg == 4'h2 && digits_reg[7:0] == 8'h01) begin
									rsp_busy_reg <= 1'b1;
									rsp_kind_reg <= `RMC_RSP_DONE;
									mode_o       <= `RMC_MODE_CMD;
									rf_enable_o  <= 1'b0;
									tag_enable_o <= 1'b0;
								end else if (ext_reg) begin
									if (ndig_reg == 4'h3 && digits_reg[11:0] == 12'h440) begin
										rsp_busy_reg <= 1'b1;
										rsp_kind_reg <= `RMC_RSP_DONE;
										uniq_reset_o <= 1'b1;
									end else if (ndig_reg == 4'h4 &&
										digits_reg[15:4] == 12'h811 &&
										digits_reg[3:2] == 2'h0) begin
										rsp_busy_reg <= 1'b1;
										rsp_kind_reg <= `RMC_RSP_DONE;
										rf_port_o    <= 4'h1 << digits_reg[1:0];
										ctag_pin_o   <= digits_reg[1];
										ctag_addr_o[digits_reg[1]] <= digits_reg[0];
										ctag_fire_o  <= 1'b1;
									end else if (ndig_reg == 4'h4 &&
										digits_reg[15:4] == 12'h815 &&
										digits_reg[3:2] == 2'h0) begin
										rsp_busy_reg <= 1'b1;
										rsp_kind_reg <= `RMC_RSP_DONE;
										ctag_addr_o[digits_reg[1]] <= digits_reg[0];
									end
								end
							end
						end
					end
					default: pstate_reg <= S_IDLE;
				endcase
			end
		end
	end
endmodule

/* tb/rmc_handler_checker.sv */
// concurrent checks on the handler's ports
`timescale 1ns/1ns
module rmc_handler_checker (
	input wire       clk_i,
	input wire       rst_i,
	input wire       tx_valid_o,
	input wire       tx_idle_i,
	input wire       msg_ready_o,
	input wire [1:0] mode_o,
	input wire [2:0] baud_sel_o,
	input wire       two_stop_o,
	input wire       xon_xoff_o,
	input wire       rf_enable_o,
	input wire       tag_enable_o,
	input wire [3:0] rf_port_o,
	input wire       uniq_reset_o,
	input wire       ctag_fire_o,
	input wire       nv_save_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_fire;
		ctag_fire_o ##1 !ctag_fire_o;
	endsequence
	a_mode_legal: assert property (mode_o != 2'h3)
		else $error("illegal mode code");
	a_msg_data_only: assert property (msg_ready_o |-> mode_o == 2'h0)
		else $error("message taken outside data mode");
	a_uniq_pulse: assert property (uniq_reset_o |=> !uniq_reset_o)
		else $error("uniqueness reset longer than one cycle");
	a_fire_once: assert property (ctag_fire_o |-> s_fire)
		else $error("check-tag fire longer than one cycle");
	a_fire_port: assert property (ctag_fire_o |-> ##[0:1] (rf_port_o != 4'h0))
		else $error("check-tag fired with no rf port on");
	a_rate_drained: assert property (($changed(baud_sel_o) && $past(mode_o) == 2'h1
		&& mode_o == 2'h1) |-> ($past(tx_idle_i) && !$past(tx_valid_o)))
		else $error("rate changed before transmit drained");
	a_dl_fixed: assert property (mode_o == 2'h2 |->
		(baud_sel_o == 3'h7 && !two_stop_o && xon_xoff_o))
		else $error("download port settings not forced");
	a_dl_quiet: assert property (mode_o == 2'h2 |->
		(!rf_enable_o && !tag_enable_o && !ctag_fire_o))
		else $error("rf or tags active in download");
	a_save_data: assert property (nv_save_o |-> ##[0:1] (mode_o == 2'h0))
		else $error("save without return to data mode");
	a_cmd_rf_off: assert property (mode_o == 2'h1 |-> (!rf_enable_o && !tag_enable_o))
		else $error("rf active in command mode");
endmodule
bind rmc_handler rmc_handler_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .tx_valid_o(tx_valid_o), .tx_idle_i(tx_idle_i),
	.msg_ready_o(msg_ready_o), .mode_o(mode_o), .baud_sel_o(baud_sel_o),
	.two_stop_o(two_stop_o), .xon_xoff_o(xon_xoff_o), .rf_enable_o(rf_enable_o),
	.tag_enable_o(tag_enable_o), .rf_port_o(rf_port_o), .uniq_reset_o(uniq_reset_o),
	.ctag_fire_o(ctag_fire_o), .nv_save_o(nv_save_o)
);

/* tb/rmc_host_model.sv */
// host serial side: takes characters, with stalls and shift time
`timescale 1ns/1ns
module rmc_host_model (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        stall_i,
	input  wire        tx_valid_i,
	input  wire  [7:0] tx_data_i,
	output wire        tx_ready_o,
	output wire        tx_idle_o,
	output reg  [39:0] last_o,
	output integer     count_o
);
	reg [2:0] busy;
	assign tx_ready_o = (busy == 3'h0) && !stall_i;
	assign tx_idle_o  = (busy == 3'h0);
	// keeps last five characters for response checks
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy <= 3'h0;
			last_o <= 40'h0;
			count_o <= 0;
		end else if (tx_valid_i && tx_ready_o) begin
			busy <= 3'h3;
			last_o <= {last_o[31:0], tx_data_i};
			count_o <= count_o + 1;
		end else if (busy != 3'h0) begin
			busy <= busy - 3'h1;
		end
	end
endmodule

/* tb/test_rmc_handler.sv */
// self-checking bench for the mode and port command handler
`timescale 1ns/1ns
module test_rmc_handler;
	reg clk_i, rst_i, rx_valid, msg_valid, dl, ext, hold, stall;
	reg [7:0] rx_data, msg_data;
	wire tx_valid_o, tx_ready, tx_idle, msg_ready_o, two_stop_o, xon_xoff_o, rf_enable_o;
	wire tag_enable_o, uniq_reset_o, ctag_fire_o, ctag_pin_o, nv_save_o, nv_dirty_o;
	wire [7:0] tx_data_o;
	wire [1:0] mode_o, ctag_addr_o;
	wire [2:0] baud_sel_o;
	wire [15:0] baud_div_o;
	wire [3:0] rf_port_o;
	wire [39:0] last;
	integer count, miscompares, cmp_count, n_uniq, n_fire, n_save, n_msg, cyc, c0;
	int unsigned seed;
	byte q[$];
	int rates[8] = '{0, 0, 1200, 2400, 4800, 9600, 19200, 38400};
	rmc_handler DUT (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .tx_data_o(tx_data_o),
		.tx_idle_i(tx_idle), .msg_valid_i(msg_valid), .msg_ready_o(msg_ready_o),
		.msg_data_i(msg_data), .download_req_i(dl), .extended_enable_i(ext),
		.mode_o(mode_o), .baud_sel_o(baud_sel_o), .baud_div_o(baud_div_o),
		.two_stop_o(two_stop_o), .xon_xoff_o(xon_xoff_o), .rf_enable_o(rf_enable_o),
		.rf_port_o(rf_port_o), .tag_enable_o(tag_enable_o), .uniq_reset_o(uniq_reset_o),
		.ctag_fire_o(ctag_fire_o), .ctag_pin_o(ctag_pin_o), .ctag_addr_o(ctag_addr_o),
		.nv_save_o(nv_save_o), .nv_dirty_o(nv_dirty_o));
	rmc_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready),
		.tx_idle_o(tx_idle), .last_o(last), .count_o(count));
	function int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task chk_resp(input [39:0] got, input [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: reply %h expected %h", $time, got, exp);
		end
	endtask
	task wait_idle;
		int n;
		n = 0;
		repeat (4) @(posedge clk_i);
		#1;
		while (n < 400 && (tx_valid_o !== 1'b0 || tx_idle !== 1'b1)) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n == 400) begin
			miscompares++;
			$display("Error %0t: transmit never drained", $time);
		end
		repeat (3) @(posedge clk_i);
	endtask
	task send(input string f);
		for (int i = 0; i < f.len(); i++) begin
			@(posedge clk_i);
			rx_valid <= 1'b1;
			rx_data <= f[i];
			@(posedge clk_i);
			rx_valid <= 1'b0;
			repeat (rnd() % 3) @(posedge clk_i);
		end
		wait_idle();
	endtask
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		stall <= hold ? 1'b1 : (rnd() % 4 == 0);
		n_uniq <= n_uniq + (uniq_reset_o === 1'b1);
		n_fire <= n_fire + (ctag_fire_o === 1'b1);
		n_save <= n_save + (nv_save_o === 1'b1);
		if (msg_valid && msg_ready_o === 1'b1) begin
			q.push_back(msg_data);
			msg_data <= 8'(rnd());
			n_msg <= n_msg + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		{rst_i, rx_valid, msg_valid, dl, ext, hold, stall, rx_data, msg_data} = 'h0;
		rst_i = 1'b1;
		{miscompares, cmp_count, n_uniq, n_fire, n_save, n_msg, cyc} = 'h0;
		seed = 33;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(mode_o, 0);
		chk(baud_sel_o, 5);
		chk(baud_div_o, 2604);
		$display("test reset done");
		hold <= 1'b1;
		repeat (10) @(posedge clk_i);
		msg_valid <= 1'b1;
		repeat (100) @(posedge clk_i);
		msg_valid <= 1'b0;
		hold <= 1'b0;
		#1;
		chk(n_msg, 16);
		wait_idle();
		chk(count, 16);
		chk_resp(last, {q[11], q[12], q[13], q[14], q[15]});
		$display("test message buffer done");
		send("#440\r");
		chk(n_uniq, 0);
		chk(count, 16);
		ext <= 1'b1;
		send("#440\r");
		chk(n_uniq, 1);
		chk_resp(last, "Done\r");
		for (int n = 0; n < 4; n++) begin
			send($sformatf("#811%0d\r", n));
			chk(rf_port_o, 1 << n);
			chk(ctag_pin_o, n / 2);
			chk(n_fire, n + 1);
		end
		for (int n = 0; n < 4; n++) begin
			send($sformatf("#815%0d\r", n));
			chk(ctag_addr_o[n / 2], n % 2);
			chk_resp(last, "Done\r");
		end
		c0 = count;
		send("#1003\r");
		chk(count, c0);
		chk(baud_sel_o, 5);
		$display("test extended data mode done");
		msg_valid <= 1'b1;
		send("#01\r");
		chk(mode_o, 1);
		chk(rf_enable_o, 0);
		chk_resp(last, "Done\r");
		for (int n = 2; n < 8; n++) begin
			send($sformatf("#100%0d\r", n));
			chk(baud_sel_o, n);
			chk(baud_div_o, 25000000 / rates[n]);
			chk_resp(last, "Done\r");
		end
		send("#1002#1006\r");
		chk(baud_sel_o, 6);
		send("#5aF\r");
		chk_resp(last, "rror\r");
		c0 = count;
		send("#5g\r");
		chk(count, c0 + 2);
		send("#1011\r");
		chk(two_stop_o, 1);
		msg_valid <= 1'b0;
		send("#00\r");
		chk(mode_o, 0);
		chk(n_save, 1);
		$display("test command mode done");
		send("#01\r");
		dl <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(mode_o, 2);
		chk(baud_sel_o, 7);
		chk(two_stop_o, 0);
		chk(xon_xoff_o, 1);
		chk(rf_enable_o, 0);
		c0 = count;
		send("#1003\r");
		chk(count, c0);
		chk(baud_sel_o, 7);
		$display("test download mode done");
		rst_i <= 1'b1;
		dl <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(mode_o, 0);
		chk(rf_enable_o, 1);
		chk(xon_xoff_o, 0);
		$display("test second reset done");
		finish_test();
	end
endmodule
